// [hdl/cps_sequencer.sv]
// module: axi4-lite driven power and path sequencer for the codec
module cps_sequencer #(
    parameter int MS_DIV = cps_pkg::MS_CYCLES
) (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire cps_pkg::cps_axi_req_type axi_req,
    output cps_pkg::cps_axi_rsp_type      axi_rsp,
    output cps_pkg::cps_ser_type          ser,
    output logic                          mclk_stop_ok
);
    import cps_pkg::*;

    typedef struct packed {
        cps_axi_rsp_type  rsp;
        logic             aw_have;
        logic [7:0]       aw_addr;
        logic             w_have;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic [31:0][7:0] image;
        logic [15:0]      lock_ms;
        logic             err;
        logic             vcm;
        logic [3:0]       act;
        logic [3:0]       op;
        logic [4:0]       idx;
        logic             last;
        cps_ph_type       ph;
        logic [15:0]      sh;
        logic [4:0]       hc;
        logic [2:0]       div;
        cps_ser_type      ser;
        logic [31:0]      ms_div;
        logic [15:0]      ms_left;
        logic             stop_ok;
    } cps_state_type;

    cps_state_type q, d;

    // build a register write step
    function automatic cps_step_type wr(logic [4:0] a, logic [7:0] s,
                                        logic [7:0] c, logic l);
        cps_step_type r;
        r = '0;
        r.addr = a;
        r.set_m = s;
        r.clr_m = c;
        r.last = l;
        return r;
    endfunction

    // build a timed wait step
    function automatic cps_step_type wt(logic [1:0] w);
        cps_step_type r;
        r = '0;
        r.is_wait = 1'b1;
        r.wsel = w;
        return r;
    endfunction

    // step table of every command; image holds the values software staged
    function automatic cps_step_type step_f(logic [3:0] op,
                                            logic [4:0] i);
        cps_step_type r;
        r = wr(RA_PWR, 8'h00, 8'h00, 1'b1);
        case (op)
            OP_INIT: begin
                r = wr(RA_PWR, PW_VCM, 8'h00, 1'b1);
            end
            OP_RECON: begin
                case (i)
                    5'd0: r = wr(RA_MODE, 8'h00, 8'h00, 1'b0);
                    5'd1: r = wr(RA_SIG1, 8'h00, 8'h00, 1'b0);
                    5'd2: r = wr(RA_TMR, 8'h00, 8'h00, 1'b0);
                    5'd3: r = wr(RA_REF, 8'h00, 8'h00, 1'b0);
                    5'd4: r = wr(RA_IVOL, 8'h00, 8'h00, 1'b0);
                    5'd5: r = wr(RA_LIM, LM_RECORD_LEVEL_CONTROL_ENABLE, 8'h00, 1'b0);
                    5'd6: r = wr(RA_SIG2, S2_FILTER_TO_SERIAL_OUT | S2_ADC_TO_FILTER,
                                 8'h00, 1'b0);
                    5'd7: r = wr(RA_FSEL, FS_RECORD_HIGHPASS_ENABLE, 8'h00, 1'b0);
                    5'd8: r = wt(W_LOCK);
                    default: r = wr(RA_PWR, PW_PFIL | PW_ADC,
                                    8'h00, 1'b1);
                endcase
            end
            OP_RECOF: begin
                r = wr(RA_PWR, 8'h00, PW_PFIL | PW_ADC, 1'b1);
            end
            OP_SPKON: begin
                case (i)
                    5'd0: r = wr(RA_MODE, 8'h00, 8'h00, 1'b0);
                    5'd1: r = wr(RA_SIG1, S1_DAC_TO_SPEAKER_PATH, 8'h00, 1'b0);
                    5'd2: r = wr(RA_TMR, 8'h00, 8'h00, 1'b0);
                    5'd3: r = wr(RA_REF, 8'h00, 8'h00, 1'b0);
                    5'd4: r = wr(RA_OVOL, 8'h00, 8'h00, 1'b0);
                    5'd5: r = wr(RA_LIM, LM_PLAYBACK_LEVEL_CONTROL_ENABLE, 8'h00, 1'b0);
                    5'd6: r = wr(RA_SIG2, S2_FILTER_TO_DAC, S2_ADC_TO_FILTER,
                                 1'b0);
                    5'd7: r = wr(RA_FSEL, FS_HPFDA, 8'h00, 1'b0);
                    5'd8: r = wt(W_LOCK);
                    5'd9: r = wr(RA_PWR, PW_DAC | PW_SPK | PW_PFIL,
                                 8'h00, 1'b0);
                    5'd10: r = wt(W_SPK);
                    default: r = wr(RA_SIG1, S1_SPEAKER_RELEASE, 8'h00, 1'b1);
                endcase
            end
            OP_SPKOF: begin
                case (i)
                    5'd0: r = wr(RA_SIG1, 8'h00, S1_SPEAKER_RELEASE, 1'b0);
                    5'd1: r = wr(RA_SIG1, 8'h00, S1_DAC_TO_SPEAKER_PATH, 1'b0);
                    default: r = wr(RA_PWR, 8'h00,
                                    PW_DAC | PW_SPK | PW_PFIL,
                                    1'b1);
                endcase
            end
            OP_BPON: begin
                // no lock wait: amplifiers run clockless
                case (i)
                    5'd0: r = wr(RA_PWR, PW_BP | PW_SPK, 8'h00,
                                 1'b0);
                    5'd1: r = wr(RA_SIG2, S2_BEEP_TO_SPEAKER_PATH, 8'h00, 1'b0);
                    5'd2: r = wt(W_BEEP);
                    default: r = wr(RA_SIG1, S1_SPEAKER_RELEASE, 8'h00,
                                    1'b1);
                endcase
            end
            OP_BPOF: begin
                case (i)
                    5'd0: r = wr(RA_SIG1, 8'h00, S1_SPEAKER_RELEASE, 1'b0);
                    5'd1: r = wr(RA_PWR, 8'h00, PW_BP | PW_SPK,
                                 1'b0);
                    default: r = wr(RA_SIG2, 8'h00, S2_BEEP_TO_SPEAKER_PATH,
                                    1'b1);
                endcase
            end
            OP_LNON: begin
                case (i)
                    5'd0: r = wr(RA_MODE, 8'h00, 8'h00, 1'b0);
                    5'd1: r = wr(RA_SIG1, S1_DAC_TO_LINE_PATH, 8'h00, 1'b0);
                    5'd2: r = wr(RA_SIG2, S2_FILTER_TO_DAC, S2_ADC_TO_FILTER, 1'b0);
                    5'd3: r = wr(RA_LIM, 8'h00, LM_PLAYBACK_LEVEL_CONTROL_ENABLE, 1'b0);
                    5'd4: r = wr(RA_OVOL, 8'h00, 8'h00, 1'b0);
                    5'd5: r = wr(RA_SIG1, S1_LINE_OUT_POWER_SAVE, 8'h00, 1'b0);
                    5'd6: r = wt(W_LOCK);
                    5'd7: r = wr(RA_PWR, PW_DAC | PW_PFIL | PW_AO,
                                 8'h00, 1'b0);
                    5'd8: r = wt(W_LINE);
                    default: r = wr(RA_SIG1, 8'h00, S1_LINE_OUT_POWER_SAVE,
                                    1'b1);
                endcase
            end
            OP_LNOF: begin
                case (i)
                    5'd0: r = wr(RA_SIG1, S1_LINE_OUT_POWER_SAVE, 8'h00, 1'b0);
                    5'd1: r = wr(RA_PWR, 8'h00, PW_DAC | PW_PFIL | PW_AO,
                                 1'b0);
                    5'd2: r = wt(W_LINE);
                    5'd3: r = wr(RA_SIG1, 8'h00, S1_DAC_TO_LINE_PATH, 1'b0);
                    default: r = wr(RA_SIG1, 8'h00, S1_LINE_OUT_POWER_SAVE,
                                    1'b1);
                endcase
            end
            default: r = wr(RA_PWR, 8'h00, 8'h00, 1'b1);
        endcase
        return r;
    endfunction

    // refusal check: act bits are rec, spk, beep, line
    function automatic logic ok_f(logic [3:0] op, logic [3:0] a,
                                  logic v);
        logic r;
        r = 1'b0;
        case (op)
            OP_INIT:  r = !v;
            OP_RECON: r = v && a == 4'h0;
            OP_SPKON: r = v && a == 4'h0;
            OP_LNON:  r = v && a == 4'h0;
            OP_BPON:  r = v && a == 4'h0;
            OP_RECOF: r = a[0];
            OP_SPKOF: r = a[1];
            OP_BPOF:  r = a[2];
            OP_LNOF:  r = a[3];
            default:  r = 1'b0;
        endcase
        return r;
    endfunction

    // read decode of the own registers
    function automatic logic [32:0] rd_f(logic [7:0] a,
                                         cps_state_type s);
        logic [32:0] r;
        r = '0;
        if (a[7]) begin
            r[7:0] = s.image[a[6:2]];
        end else if (a == OF_CTRL) begin
            r[3:0] = s.op;
        end else if (a == OF_STAT) begin
            r[ST_BUSY] = s.ph != P_IDLE;
            r[ST_VCM] = s.vcm;
            r[ST_ERR] = s.err;
            r[ST_CLK] = s.stop_ok;
            r[ST_ACT +: 4] = s.act;
        end else if (a == OF_LOCK) begin
            r[15:0] = s.lock_ms;
        end else begin
            r[32] = 1'b1;
        end
        return r;
    endfunction

    // next state
    always_comb begin
        cps_step_type s;
        logic [7:0]   v;
        logic [32:0]  rd;
        logic         err_set;
        logic         err_clr;
        logic         fin;
        d = q;
        s = step_f(q.op, q.idx);
        v = 8'h00;
        rd = 33'h0;
        err_set = 1'b0;
        err_clr = 1'b0;
        fin = 1'b0;
        // write address and data are taken in either order
        if (axi_req.awvalid && q.rsp.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = axi_req.awaddr;
            d.rsp.awready = 1'b0;
        end
        if (axi_req.wvalid && q.rsp.wready) begin
            d.w_have = 1'b1;
            d.w_data = axi_req.wdata;
            d.w_strb = axi_req.wstrb;
            d.rsp.wready = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = RESP_OK;
            if (q.aw_addr[7]) begin
                if (q.w_strb[0]) begin
                    d.image[q.aw_addr[6:2]] = q.w_data[7:0];
                end
            end else if (q.aw_addr == OF_CTRL) begin
                if (q.w_strb[0] && q.w_data[3:0] != OP_NONE) begin
                    if (q.ph == P_IDLE &&
                        ok_f(q.w_data[3:0], q.act, q.vcm)) begin
                        d.op = q.w_data[3:0];
                        d.idx = 5'd0;
                        d.ph = P_FETCH;
                    end else begin
                        err_set = 1'b1;
                    end
                end
            end else if (q.aw_addr == OF_STAT) begin
                err_clr = q.w_strb[0] && q.w_data[ST_ERR];
            end else if (q.aw_addr == OF_LOCK) begin
                if (q.w_strb[0]) begin
                    d.lock_ms[7:0] = q.w_data[7:0];
                end
                if (q.w_strb[1]) begin
                    d.lock_ms[15:8] = q.w_data[15:8];
                end
            end else begin
                d.rsp.bresp = RESP_ERR;
            end
        end
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid = 1'b0;
            d.rsp.awready = 1'b1;
            d.rsp.wready = 1'b1;
        end
        // read channel, one outstanding
        if (axi_req.arvalid && q.rsp.arready) begin
            rd = rd_f(axi_req.araddr, q);
            d.rsp.arready = 1'b0;
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata = rd[31:0];
            d.rsp.rresp = rd[32] ? RESP_ERR : RESP_OK;
        end
        if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid = 1'b0;
            d.rsp.arready = 1'b1;
        end
        // sequencer
        case (q.ph)
            P_FETCH: begin
                d.last = s.last;
                if (s.is_wait) begin
                    d.ms_div = 32'h0;
                    case (s.wsel)
                        W_SPK:   d.ms_left = 16'(SPK_WAIT_MS);
                        W_BEEP:  d.ms_left = 16'(BEEP_SETTLE_MS);
                        W_LINE:  d.ms_left = 16'(LINE_RAMP_MS);
                        default: d.ms_left = q.lock_ms;
                    endcase
                    d.ph = P_WAIT;
                end else begin
                    v = (q.image[s.addr] & ~s.clr_m) | s.set_m;
                    d.image[s.addr] = v;
                    d.sh = {SER_HDR, s.addr, v};
                    d.hc = 5'd0;
                    d.div = 3'd0;
                    d.ser.csn = 1'b0;
                    d.ser.sclk = 1'b0;
                    d.ser.sdo = SER_HDR[2];
                    d.ph = P_SHIFT;
                end
            end
            P_SHIFT: begin
                // data changes on the falling clock, device samples on rise
                d.div = q.div + 3'd1;
                if (q.div == 3'(SER_HALF_CYCLES - 1)) begin
                    d.div = 3'd0;
                    d.hc = q.hc + 5'd1;
                    if (!q.hc[0]) begin
                        d.ser.sclk = 1'b1;
                    end else begin
                        d.ser.sclk = 1'b0;
                        if (q.hc == 5'd31) begin
                            d.ser.csn = 1'b1;
                            fin = 1'b1;
                        end else begin
                            d.sh = {q.sh[14:0], 1'b0};
                            d.ser.sdo = q.sh[14];
                        end
                    end
                end
            end
            P_WAIT: begin
                // ms tick counted from step start: never shorter than asked
                if (q.ms_left == 16'h0) begin
                    fin = 1'b1;
                end else if (q.ms_div == 32'(MS_DIV - 1)) begin
                    d.ms_div = 32'h0;
                    d.ms_left = q.ms_left - 16'h1;
                end else begin
                    d.ms_div = q.ms_div + 32'h1;
                end
            end
            default: begin
            end
        endcase
        if (fin) begin
            d.idx = q.idx + 5'd1;
            d.ph = P_FETCH;
            if (q.last) begin
                d.ph = P_IDLE;
                case (q.op)
                    OP_INIT:  d.vcm = 1'b1;
                    OP_RECON: d.act[0] = 1'b1;
                    OP_RECOF: d.act[0] = 1'b0;
                    OP_SPKON: d.act[1] = 1'b1;
                    OP_SPKOF: d.act[1] = 1'b0;
                    OP_BPON:  d.act[2] = 1'b1;
                    OP_BPOF:  d.act[2] = 1'b0;
                    OP_LNON:  d.act[3] = 1'b1;
                    OP_LNOF:  d.act[3] = 1'b0;
                    default:  d.act = q.act;
                endcase
            end
        end
        // set wins over clear
        d.err = (q.err && !err_clr) || err_set;
        // drops at once on power-up, rises after the power-down frame has left,
        // or on a staged RA_PWR write that clears the clock bits, ahead of the device
        d.stop_ok = ((d.image[RA_PWR] & PW_CLK) == 8'h00) &&
                    (q.stop_ok || d.ph != P_SHIFT);
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.rsp.awready <= 1'b1;
            q.rsp.wready <= 1'b1;
            q.rsp.arready <= 1'b1;
            q.ser.csn <= 1'b1;
            q.stop_ok <= 1'b1;
            q.ph <= P_IDLE;
        end else begin
            q <= d;
        end
    end

    assign axi_rsp = q.rsp;
    assign ser = q.ser;
    assign mclk_stop_ok = q.stop_ok;
endmodule

// [hdl/cps_pkg.sv]
// package: constants, carriers and device map for the path sequencer
package cps_pkg;
    // clock and timing
    localparam int CLK_NS          = 25;
    localparam int MS_NS           = 1_000_000;
    localparam int MS_CYCLES       = (MS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SPK_WAIT_MS     = 1;
    localparam int BEEP_SETTLE_MS  = 10;
    localparam int LINE_RAMP_MS    = 300;
    localparam int SER_HALF_CYCLES = 4;
    // device register addresses
    localparam logic [4:0] RA_PWR  = 5'h00;
    localparam logic [4:0] RA_SIG1 = 5'h02;
    localparam logic [4:0] RA_SIG2 = 5'h03;
    localparam logic [4:0] RA_MODE = 5'h05;
    localparam logic [4:0] RA_TMR  = 5'h06;
    localparam logic [4:0] RA_LIM  = 5'h07;
    localparam logic [4:0] RA_REF  = 5'h08;
    localparam logic [4:0] RA_IVOL = 5'h09;
    localparam logic [4:0] RA_OVOL = 5'h0A;
    localparam logic [4:0] RA_FSEL = 5'h0E;
    // power register bits
    localparam logic [7:0] PW_ADC  = 8'h01;
    localparam logic [7:0] PW_DAC  = 8'h04;
    localparam logic [7:0] PW_AO   = 8'h08;
    localparam logic [7:0] PW_SPK  = 8'h10;
    localparam logic [7:0] PW_BP   = 8'h20;
    localparam logic [7:0] PW_VCM  = 8'h40;
    localparam logic [7:0] PW_PFIL = 8'h80;
    localparam logic [7:0] PW_CLK  = 8'h85;
    // path bits
    localparam logic [7:0] S1_DAC_TO_SPEAKER_PATH  = 8'h08;
    localparam logic [7:0] S1_DAC_TO_LINE_PATH  = 8'h10;
    localparam logic [7:0] S1_LINE_OUT_POWER_SAVE  = 8'h40;
    localparam logic [7:0] S1_SPEAKER_RELEASE = 8'h80;
    localparam logic [7:0] S2_ADC_TO_FILTER = 8'h01;
    localparam logic [7:0] S2_FILTER_TO_SERIAL_OUT = 8'h02;
    localparam logic [7:0] S2_FILTER_TO_DAC = 8'h04;
    localparam logic [7:0] S2_BEEP_TO_SPEAKER_PATH = 8'h20;
    localparam logic [7:0] LM_RECORD_LEVEL_CONTROL_ENABLE  = 8'h20;
    localparam logic [7:0] LM_PLAYBACK_LEVEL_CONTROL_ENABLE  = 8'h40;
    localparam logic [7:0] FS_RECORD_HIGHPASS_ENABLE = 8'h01;
    localparam logic [7:0] FS_HPFDA = 8'h02;
    localparam logic [2:0] SER_HDR  = 3'h1;
    // own register map and fields
    localparam logic [7:0] OF_CTRL  = 8'h00;
    localparam logic [7:0] OF_STAT  = 8'h04;
    localparam logic [7:0] OF_LOCK  = 8'h08;
    localparam int ST_BUSY = 0;
    localparam int ST_VCM  = 1;
    localparam int ST_ERR  = 2;
    localparam int ST_CLK  = 3;
    localparam int ST_ACT  = 4;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // commands
    localparam logic [3:0] OP_NONE  = 4'h0;
    localparam logic [3:0] OP_INIT  = 4'h1;
    localparam logic [3:0] OP_RECON = 4'h2;
    localparam logic [3:0] OP_RECOF = 4'h3;
    localparam logic [3:0] OP_SPKON = 4'h4;
    localparam logic [3:0] OP_SPKOF = 4'h5;
    localparam logic [3:0] OP_BPON  = 4'h6;
    localparam logic [3:0] OP_BPOF  = 4'h7;
    localparam logic [3:0] OP_LNON  = 4'h8;
    localparam logic [3:0] OP_LNOF  = 4'h9;
    localparam logic [1:0] W_LOCK = 2'h0;
    localparam logic [1:0] W_SPK  = 2'h1;
    localparam logic [1:0] W_BEEP = 2'h2;
    localparam logic [1:0] W_LINE = 2'h3;

    typedef enum logic [1:0] {P_IDLE, P_FETCH, P_SHIFT, P_WAIT} cps_ph_type;

    typedef struct packed {
        logic       last;
        logic       is_wait;
        logic [1:0] wsel;
        logic [4:0] addr;
        logic [7:0] set_m;
        logic [7:0] clr_m;
    } cps_step_type;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } cps_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cps_axi_rsp_type;

    typedef struct packed {
        logic csn;
        logic sclk;
        logic sdo;
    } cps_ser_type;
endpackage

// [verification/cps_sequencer_chk.sv]
// checker: mirrors control frames into a device image, checks ordering
module cps_sequencer_chk #(
    parameter int MS_DIV = cps_pkg::MS_CYCLES
) (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire cps_pkg::cps_axi_req_type axi_req,
    input wire cps_pkg::cps_axi_rsp_type axi_rsp,
    input wire cps_pkg::cps_ser_type     ser,
    input wire logic                     mclk_stop_ok
);
    timeunit 1ns;
    timeprecision 100ps;
    import cps_pkg::*;
    logic [15:0] sh;
    logic [7:0]  img [32];
    logic        sclk_p;
    logic        csn_p;
    int          spk_cnt;
    int          ao_cnt;
    wire         fe = ser.csn && !csn_p;
    wire         pw = fe && sh[12:8] == RA_PWR;
    wire         s1 = fe && sh[12:8] == RA_SIG1;
    wire [7:0]   fd = sh[7:0];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // image lands when csn closes a frame; counters time the waits
    always_ff @(posedge aclk) begin
        sclk_p  <= ser.sclk;
        csn_p   <= ser.csn || !aresetn;
        spk_cnt <= img[0][4] ? spk_cnt + 1 : 0;
        ao_cnt  <= (!aresetn || pw && fd[3] != img[0][3]) ? 0 : ao_cnt + 1;
        if (ser.sclk && !sclk_p) sh <= {sh[14:0], ser.sdo};
        if (!aresetn) img <= '{default: 8'h00};
        else if (fe) img[sh[12:8]] <= fd;
    end
    sequence s_open;
        !ser.sclk [*4] ##1 ser.sclk;
    endsequence
    a_frame_open:
    assert property ($fell(ser.csn) |-> s_open) else $error("frame start");
    a_vcom_first:
    assert property (fe |-> img[0][6] || pw && fd == PW_VCM)
        else $error("reference not first");
    a_adc_pair:
    assert property (pw && fd[0] != img[0][0] |-> fd[7] == fd[0])
        else $error("adc and filter apart");
    a_rec_path:
    assert property (pw && fd[0] && !img[0][0] |->
        img[3][1:0] == 2'h3 && img[14][0]) else $error("record path");
    a_dac_path:
    assert property (pw && fd[2] && !img[0][2] |-> img[2][3] || img[2][4])
        else $error("dac without path");
    // the release frame itself lasts 32 half periods: the wait precedes it
    a_spk_wait:
    assert property (s1 && fd[7] && !img[2][7] |->
        spk_cnt >= MS_DIV + 32 * SER_HALF_CYCLES)
        else $error("early release");
    a_spk_save:
    assert property (pw && !fd[4] && img[0][4] |-> !img[2][7])
        else $error("speaker off while released");
    a_line_save:
    assert property (pw && fd[3] && !img[0][3] |-> img[2][6])
        else $error("line on outside save");
    a_line_ramp:
    assert property (s1 && !fd[6] && img[2][6] |->
        ao_cnt >= LINE_RAMP_MS * MS_DIV) else $error("line save left early");
    a_clk_stop:
    assert property (pw |-> mclk_stop_ok == ((fd & PW_CLK) == 8'h00))
        else $error("clock stop flag");
    a_clk_early:
    assert property (mclk_stop_ok && !fe |-> (img[0] & PW_CLK) == 8'h00)
        else $error("clock stop flag early");
endmodule
bind cps_sequencer cps_sequencer_chk #(.MS_DIV(MS_DIV)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .ser(ser), .mclk_stop_ok(mclk_stop_ok));

// [verification/cps_codec_model.sv]
// device model: latches control frames and shows speaker pin state
module cps_codec_model (
    input  wire cps_pkg::cps_ser_type ser,
    output logic [7:0]                regs [32],
    output logic [1:0]                spk_state
);
    timeunit 1ns;
    timeprecision 100ps;
    import cps_pkg::*;
    logic [15:0] sh;
    initial regs = '{default: 8'h00};
    // data sampled on the rising serial clock, msb first
    always @(posedge ser.sclk) if (!ser.csn) sh <= {sh[14:0], ser.sdo};
    // a frame only takes effect once chip select closes it, and only
    // when its three header bits match SER_HDR
    always @(posedge ser.csn)
        if (sh[15:13] == SER_HDR) regs[sh[12:8]] <= sh[7:0];
    // 0 hi-z, 1 mid-supply, 2 driving; no clock here, so beep works bare
    assign spk_state = !regs[0][4] ? 2'h0 :
                       regs[2][7] ? 2'h2 : 2'h1;
endmodule

// [verification/cps_sequencer_bench.sv]
// bench: runs each path sequence and judges the device image left behind
module cps_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cps_pkg::*;
    logic            aclk;
    logic            aresetn;
    logic            mclk_stop_ok;
    cps_axi_req_type q;
    cps_axi_rsp_type r;
    cps_ser_type     ser;
    logic [7:0]      regs [32];
    logic [1:0]      spk;
    logic [31:0]     d;
    logic [1:0]      rs;
    int              miscompares = 0;
    int              cmp_count = 0;
    // one ms is 10 cycles here so the 300 ms ramps stay short
    cps_sequencer #(.MS_DIV(10)) dut (.aclk(aclk), .aresetn(aresetn),
        .axi_req(q), .axi_rsp(r), .ser(ser), .mclk_stop_ok(mclk_stop_ok));
    cps_codec_model dev (.ser(ser), .regs(regs), .spk_state(spk));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one axi transfer; the channels are looked at on the falling edge so
    // the dut's own update at the rising edge is never raced
    task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        logic aw_t;
        logic w_t;
        logic ar_t;
        logic done;
        @(posedge aclk);
        q <= '{w, a, w, v, 4'hF, w, !w, a, !w};
        do begin
            @(negedge aclk);
            aw_t = q.awvalid && r.awready;
            w_t = q.wvalid && r.wready;
            ar_t = q.arvalid && r.arready;
            done = w ? r.bvalid : r.rvalid;
            d = r.rdata;
            rs = w ? r.bresp : r.rresp;
            @(posedge aclk);
            if (aw_t) q.awvalid <= 1'b0;
            if (w_t) q.wvalid <= 1'b0;
            if (ar_t) q.arvalid <= 1'b0;
        end while (!done);
        q.bready <= 1'b0;
        q.rready <= 1'b0;
    endtask
    // command, then poll status until busy clears
    task cmd(input logic [3:0] c);
        bus(1'b1, OF_CTRL, {28'h0, c});
        do bus(1'b0, OF_STAT, 32'h0);
        while (d[ST_BUSY]);
    endtask
    task stage(input logic [4:0] a, input logic [7:0] v);
        bus(1'b1, {1'b1, a, 2'h0}, {24'h0, v});
    endtask
    // a refused command leaves the error flag up; writing one clears it
    task refused();
        bus(1'b0, OF_STAT, 32'h0);
        chk(32'(d[ST_ERR]), 32'h1);
        bus(1'b1, OF_STAT, 32'h4);
    endtask
    task t_init();
        bus(1'b0, OF_STAT, 32'h0);
        chk(d, 32'h8);
        bus(1'b1, 8'h40, 32'h1);
        chk(32'(rs), 32'(RESP_ERR));
        cmd(OP_RECON);
        refused();
        cmd(OP_INIT);
        bus(1'b0, OF_STAT, 32'h0);
        chk({d[7:0], regs[0]}, {8'h0A, PW_VCM});
        $display("init test done");
    endtask
    // short init and a 2 ms lock wait; a start while recording is refused
    task t_rec();
        bus(1'b1, OF_LOCK, 32'h2);
        stage(RA_MODE, 8'h80);
        stage(RA_IVOL, 8'h5A);
        cmd(OP_RECON);
        chk({regs[5], regs[9], regs[7]}, 24'h805A20);
        chk({regs[3], regs[14]}, 16'h0301);
        chk({regs[0], 7'h0, mclk_stop_ok}, 16'hC100);
        cmd(OP_SPKON);
        refused();
        cmd(OP_RECOF);
        chk({regs[0], 7'h0, mclk_stop_ok}, 16'h4001);
        $display("record test done");
    endtask
    // playback, a stop of an idle path, then beep on and off
    task t_spk();
        stage(RA_OVOL, 8'h33);
        cmd(OP_SPKON);
        chk({regs[10], regs[7], 6'h0, spk}, 24'h336002);
        chk({regs[0], regs[2]}, 16'hD488);
        chk({regs[3], regs[14]}, 16'h0603);
        cmd(OP_SPKOF);
        chk({regs[0], regs[2], 6'h0, spk}, 24'h400000);
        cmd(OP_SPKOF);
        refused();
        cmd(OP_BPON);
        chk({regs[0], regs[2], regs[3]}, 24'h708026);
        cmd(OP_BPOF);
        chk({regs[0], regs[2], regs[3]}, 24'h400006);
        $display("speaker test done");
    endtask
    task t_line();
        stage(RA_LIM, 8'h40);
        stage(RA_OVOL, 8'h21);
        cmd(OP_LNON);
        chk({regs[0], regs[2]}, 16'hCC10);
        chk({regs[7], regs[10]}, 16'h0021);
        cmd(OP_LNOF);
        chk({regs[0], regs[2]}, 16'h4000);
        chk(32'(mclk_stop_ok), 32'h1);
        $display("line test done");
    endtask
    task end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        aresetn = 1'b0;
        q = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_init();
        t_rec();
        t_spk();
        t_line();
        end_of_test();
    end
    // about 12k cycles expected; eight times that means a hang
    initial begin
        repeat (100000) @(posedge aclk);
        miscompares++;
        end_of_test();
    end
endmodule
